// ### design/mac_frame_pkg.sv
package mac_frame_pkg;

  // Fixed octet values of the frame fields.
  localparam logic [7:0] PREAMBLE_BYTE = 8'h55;
  localparam logic [7:0] START_DELIMITER = 8'hD5;
  localparam logic [15:0] VLAN_TAG = 16'h8100;
  localparam logic [15:0] TYPE_THRESHOLD = 16'h0600;
  localparam logic [15:0] PAUSE_TYPE = 16'h8808;
  localparam logic [15:0] PAUSE_OPCODE = 16'h0001;

  // Field lengths in octets, sized to the byte counters they meet.
  localparam logic [13:0] PREAMBLE_LEN = 14'h0007;
  localparam logic [13:0] ADDR_LEN = 14'h0006;
  localparam logic [13:0] LTYPE_LEN = 14'h0002;
  localparam logic [13:0] VLAN_ONE_LEN = 14'h0004;
  localparam logic [13:0] VLAN_TWO_LEN = 14'h0008;
  localparam logic [13:0] FCS_LEN = 14'h0004;
  localparam logic [13:0] PAUSE_BODY_LEN = 14'h0004;
  localparam logic [13:0] PAUSE_PAD = 14'h002A;
  localparam logic [13:0] PAD_UNTAGGED = 14'h002E;
  localparam logic [13:0] PAD_SINGLE = 14'h002A;
  localparam logic [13:0] PAD_STACKED = 14'h0026;
  localparam logic [13:0] MAX_PAYLOAD = 14'h05DC;
  localparam logic [13:0] MAX_JUMBO = 14'h2580;
  localparam logic [13:0] IPG_LEN = 14'h000C;

  // Ethernet CRC-32, reflected form, sent inverted.
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_POLY = 32'hEDB88320;

  // Register byte addresses on the APB.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_DA_LO = 8'h04;
  localparam logic [7:0] OFS_DA_HI = 8'h08;
  localparam logic [7:0] OFS_SA_LO = 8'h0C;
  localparam logic [7:0] OFS_SA_HI = 8'h10;
  localparam logic [7:0] OFS_LEN_TYPE = 8'h14;
  localparam logic [7:0] OFS_VLAN_INFO = 8'h18;
  localparam logic [7:0] OFS_QUANTA = 8'h1C;
  localparam logic [7:0] OFS_SECTION_EMPTY = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;

  // Control register fields.
  localparam int CTRL_TX_ENA = 0;
  localparam int CTRL_FC_ENA = 1;
  localparam int CTRL_XOFF = 2;
  localparam int CTRL_XON = 3;
  localparam int CTRL_VLAN_LSB = 4;
  localparam int CTRL_JUMBO = 6;
  localparam int CTRL_WIDTH = 7;

  // Status register fields.
  localparam int STAT_BUSY = 0;
  localparam int STAT_PAUSE = 1;
  localparam int STAT_IS_TYPE = 2;
  localparam int STAT_OVERSIZE = 3;
  localparam int STAT_UNDERRUN = 4;
  localparam int STAT_LEN_MISMATCH = 5;

  // Reset values.
  localparam logic [6:0] CTRL_RESET = 7'h00;
  localparam logic [15:0] QUANTA_RESET = 16'h000F;
  localparam logic [15:0] SECTION_EMPTY_RESET = 16'hFFFF;

  typedef enum logic [1:0] {
    VLAN_NONE = 2'b00,
    VLAN_SINGLE = 2'b01,
    VLAN_STACKED = 2'b10
  } vlan_mode_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_PREAMBLE = 4'b0001,
    ST_DELIM = 4'b0010,
    ST_DEST = 4'b0011,
    ST_SRC = 4'b0100,
    ST_VLAN = 4'b0101,
    ST_LTYPE = 4'b0110,
    ST_PAYLOAD = 4'b0111,
    ST_PAD = 4'b1000,
    ST_FCS = 4'b1001,
    ST_GAP = 4'b1010
  } tx_state_t;

  // One payload byte from the client with its end-of-frame mark.
  typedef struct packed {
    logic [7:0] data;
    logic last;
  } client_beat_t;

endpackage

// ### design/mac_frame_tx.sv
// What this block does
// - Each frame starts with seven preamble octets of 0x55.
// - One start delimiter octet 0xD5 follows the preamble.
// - Destination and source addresses are six octets, least significant byte first.
// - Length/type of 1536 or more is a type, smaller is a payload length.
// - Length/type goes out most significant byte first.
// - Every frame ends with a four-octet CRC value.
// - No half-duplex gigabit extension field is ever produced.
// - Payload up to 1500 or 9600 octets; untagged frames padded 0 to 46.
// - A tagged frame carries 0x8100 and two VLAN info octets after the source.
// - With jumbo off, single-tagged frames are limited to 1522 bytes without preamble and delimiter, stacked frames to 1526.
// - Stacked frames carry two tag pairs, pad range drops to 0 to 38.
// - Pause frames carry type 0x8808 then opcode 0x0001.
// - Pause quanta follows the opcode, high byte first.
// - Pause frames have no length field and 42 zero pad bytes.
// - A station receiving pause frames should stop sending data.
// - With flow control on, fill threshold, register bits or pins start pause frames.
// - With flow control on, an almost full receive FIFO automatically triggers a pause frame.
// - XOFF alone keeps XOFF pause frames going until it clears.
// - XON alone keeps XON pause frames going until it clears.
// - XOFF pause frames carry the programmed pause quanta.
//
// The APB slave port and the register offsets were chosen for this implementation.
module mac_frame_tx #(
  parameter logic [47:0] PAUSE_DEST_ADDR = 48'h000000000000
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic client_valid,
  input wire mac_frame_pkg::client_beat_t client_beat,
  output logic client_ready,
  input wire logic [15:0] rx_fill_level,
  input wire logic xoff_gen_pin,
  input wire logic xon_gen_pin,
  output logic [7:0] txd,
  output logic tx_en,
  output logic pause_active
);

  mac_frame_pkg::tx_state_t state, next_state;
  logic [13:0] cnt, pay_cnt;
  logic [31:0] crc;
  logic [6:0] ctrl;
  logic [47:0] dest_addr, src_addr;
  logic [15:0] len_type, quanta, section_empty, frame_quanta;
  logic [31:0] vlan_info;
  logic is_pause, discard, above_d, auto_pend;
  logic st_is_type, st_oversize, st_underrun, st_mismatch;
  logic [1:0] sync1, sync2, sync3;
  logic [1:0] pin_level;

  function automatic logic [31:0] crc_next(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ mac_frame_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  function automatic logic [7:0] addr_byte(input logic [47:0] a, input logic [13:0] i);
    return a[8 * i[2:0] +: 8];
  endfunction

  function automatic logic addr_known(input logic [7:0] a);
    return a == mac_frame_pkg::OFS_CTRL || a == mac_frame_pkg::OFS_DA_LO ||
      a == mac_frame_pkg::OFS_DA_HI || a == mac_frame_pkg::OFS_SA_LO ||
      a == mac_frame_pkg::OFS_SA_HI || a == mac_frame_pkg::OFS_LEN_TYPE ||
      a == mac_frame_pkg::OFS_VLAN_INFO || a == mac_frame_pkg::OFS_QUANTA ||
      a == mac_frame_pkg::OFS_SECTION_EMPTY || a == mac_frame_pkg::OFS_STATUS;
  endfunction

  // Control fields and derived frame shape.
  wire tx_ena = ctrl[mac_frame_pkg::CTRL_TX_ENA];
  wire fc_ena = ctrl[mac_frame_pkg::CTRL_FC_ENA];
  wire jumbo = ctrl[mac_frame_pkg::CTRL_JUMBO];
  wire [1:0] vlan_mode = ctrl[mac_frame_pkg::CTRL_VLAN_LSB +: 2];
  wire single_tag = vlan_mode == mac_frame_pkg::VLAN_SINGLE;
  wire stacked_tag = vlan_mode == mac_frame_pkg::VLAN_STACKED;
  wire has_tag = !is_pause && (single_tag || stacked_tag);
  wire [13:0] vlan_len = stacked_tag ? mac_frame_pkg::VLAN_TWO_LEN
    : mac_frame_pkg::VLAN_ONE_LEN;
  wire [13:0] pad_base = is_pause ? (mac_frame_pkg::PAUSE_BODY_LEN + mac_frame_pkg::PAUSE_PAD)
    : stacked_tag ? mac_frame_pkg::PAD_STACKED
    : single_tag ? mac_frame_pkg::PAD_SINGLE : mac_frame_pkg::PAD_UNTAGGED;
  wire [13:0] max_pay = jumbo ? mac_frame_pkg::MAX_JUMBO : mac_frame_pkg::MAX_PAYLOAD;

  // Pause requests: register bits or filtered pins, plus the fill threshold.
  wire xoff_req = ctrl[mac_frame_pkg::CTRL_XOFF] | pin_level[0];
  wire xon_req = ctrl[mac_frame_pkg::CTRL_XON] | pin_level[1];
  wire above = rx_fill_level >= section_empty;
  wire pause_go = fc_ena && (xoff_req || xon_req || auto_pend);
  wire client_go = tx_ena && client_valid && !discard;
  wire take = client_valid && client_ready;
  wire last_pay = pay_cnt == max_pay - 14'h0001;
  wire pay_done = is_pause ? (pay_cnt == mac_frame_pkg::PAUSE_BODY_LEN - 14'h0001)
    : (take && (client_beat.last || last_pay));
  // Pad octets always count, so client and pause frames stop padding on the same octet.
  wire [13:0] pay_next = pay_cnt + ((is_pause || take || state == mac_frame_pkg::ST_PAD) ?
    14'h0001 : 14'h0000);
  wire need_pad = pay_next < pad_base;
  wire in_crc = state inside {mac_frame_pkg::ST_DEST, mac_frame_pkg::ST_SRC,
    mac_frame_pkg::ST_VLAN, mac_frame_pkg::ST_LTYPE, mac_frame_pkg::ST_PAYLOAD,
    mac_frame_pkg::ST_PAD};

  // Next state; the frame ends after the check value, with no extension field.
  always_comb begin
    next_state = state;
    case (state)
      mac_frame_pkg::ST_IDLE: begin
        if (pause_go || client_go) begin
          next_state = mac_frame_pkg::ST_PREAMBLE;
        end
      end
      mac_frame_pkg::ST_PREAMBLE: begin
        if (cnt == mac_frame_pkg::PREAMBLE_LEN - 14'h0001) begin
          next_state = mac_frame_pkg::ST_DELIM;
        end
      end
      mac_frame_pkg::ST_DELIM: next_state = mac_frame_pkg::ST_DEST;
      mac_frame_pkg::ST_DEST: begin
        if (cnt == mac_frame_pkg::ADDR_LEN - 14'h0001) begin
          next_state = mac_frame_pkg::ST_SRC;
        end
      end
      mac_frame_pkg::ST_SRC: begin
        if (cnt == mac_frame_pkg::ADDR_LEN - 14'h0001) begin
          next_state = has_tag ? mac_frame_pkg::ST_VLAN : mac_frame_pkg::ST_LTYPE;
        end
      end
      mac_frame_pkg::ST_VLAN: begin
        if (cnt == vlan_len - 14'h0001) begin
          next_state = mac_frame_pkg::ST_LTYPE;
        end
      end
      mac_frame_pkg::ST_LTYPE: begin
        if (cnt == mac_frame_pkg::LTYPE_LEN - 14'h0001) begin
          next_state = mac_frame_pkg::ST_PAYLOAD;
        end
      end
      mac_frame_pkg::ST_PAYLOAD: begin
        if (pay_done) begin
          next_state = need_pad ? mac_frame_pkg::ST_PAD : mac_frame_pkg::ST_FCS;
        end
      end
      mac_frame_pkg::ST_PAD: begin
        if (!need_pad) begin
          next_state = mac_frame_pkg::ST_FCS;
        end
      end
      mac_frame_pkg::ST_FCS: begin
        if (cnt == mac_frame_pkg::FCS_LEN - 14'h0001) begin
          next_state = mac_frame_pkg::ST_GAP;
        end
      end
      mac_frame_pkg::ST_GAP: begin
        if (cnt == mac_frame_pkg::IPG_LEN - 14'h0001) begin
          next_state = mac_frame_pkg::ST_IDLE;
        end
      end
      default: next_state = mac_frame_pkg::ST_IDLE;
    endcase
  end

  // Octet on the line for the present state and count.
  logic [7:0] cur_byte;
  logic [15:0] vlan_word;
  always_comb begin
    vlan_word = (cnt < mac_frame_pkg::VLAN_ONE_LEN) ? vlan_info[15:0] : vlan_info[31:16];
    cur_byte = 8'h00;
    case (state)
      mac_frame_pkg::ST_PREAMBLE: cur_byte = mac_frame_pkg::PREAMBLE_BYTE;
      mac_frame_pkg::ST_DELIM: cur_byte = mac_frame_pkg::START_DELIMITER;
      mac_frame_pkg::ST_DEST: begin
        cur_byte = addr_byte(is_pause ? PAUSE_DEST_ADDR : dest_addr, cnt);
      end
      mac_frame_pkg::ST_SRC: cur_byte = addr_byte(src_addr, cnt);
      mac_frame_pkg::ST_VLAN: begin
        case (cnt[1:0])
          2'h0: cur_byte = mac_frame_pkg::VLAN_TAG[15:8];
          2'h1: cur_byte = mac_frame_pkg::VLAN_TAG[7:0];
          2'h2: cur_byte = vlan_word[15:8];
          default: cur_byte = vlan_word[7:0];
        endcase
      end
      mac_frame_pkg::ST_LTYPE: begin
        cur_byte = (cnt == 14'h0000) ? (is_pause ? mac_frame_pkg::PAUSE_TYPE[15:8]
          : len_type[15:8]) : (is_pause ? mac_frame_pkg::PAUSE_TYPE[7:0]
          : len_type[7:0]);
      end
      mac_frame_pkg::ST_PAYLOAD: begin
        if (!is_pause) begin
          cur_byte = take ? client_beat.data : 8'h00;
        end else begin
          case (pay_cnt[1:0])
            2'h0: cur_byte = mac_frame_pkg::PAUSE_OPCODE[15:8];
            2'h1: cur_byte = mac_frame_pkg::PAUSE_OPCODE[7:0];
            2'h2: cur_byte = frame_quanta[15:8];
            default: cur_byte = frame_quanta[7:0];
          endcase
        end
      end
      mac_frame_pkg::ST_FCS: cur_byte = ~crc[8 * cnt[1:0] +: 8];
      default: cur_byte = 8'h00;
    endcase
  end

  wire cur_en = state != mac_frame_pkg::ST_IDLE && state != mac_frame_pkg::ST_GAP;

  // Frame sequencer, line outputs and CRC accumulation.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= mac_frame_pkg::ST_IDLE;
      cnt <= 14'h0000;
      pay_cnt <= 14'h0000;
      crc <= mac_frame_pkg::CRC_INIT;
      txd <= 8'h00;
      tx_en <= 1'b0;
      is_pause <= 1'b0;
      frame_quanta <= 16'h0000;
      pause_active <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= (next_state != state) ? 14'h0000 : cnt + 14'h0001;
      txd <= cur_byte;
      tx_en <= cur_en;
      pause_active <= (next_state != mac_frame_pkg::ST_IDLE) &&
        ((state == mac_frame_pkg::ST_IDLE) ? pause_go : is_pause);
      if (state == mac_frame_pkg::ST_DELIM) begin
        crc <= mac_frame_pkg::CRC_INIT;
      end else if (in_crc) begin
        crc <= crc_next(crc, cur_byte);
      end
      if (state == mac_frame_pkg::ST_LTYPE) begin
        pay_cnt <= 14'h0000;
      end else if (state == mac_frame_pkg::ST_PAYLOAD || state == mac_frame_pkg::ST_PAD) begin
        pay_cnt <= (state == mac_frame_pkg::ST_PAD) ? pay_cnt + 14'h0001 : pay_next;
      end
      // Pause wins the idle slot so flow control is never starved by client traffic.
      if (state == mac_frame_pkg::ST_IDLE && next_state != mac_frame_pkg::ST_IDLE) begin
        is_pause <= pause_go;
        frame_quanta <= (xoff_req || auto_pend) ? quanta : 16'h0000;
      end
    end
  end

  // Client handshake; an oversize frame is cut and its tail absorbed.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      client_ready <= 1'b0;
      discard <= 1'b0;
    end else begin
      client_ready <= (next_state == mac_frame_pkg::ST_PAYLOAD && !is_pause) ||
        (discard && !(take && client_beat.last)) ||
        (state == mac_frame_pkg::ST_PAYLOAD && take && last_pay && !client_beat.last);
      if (state == mac_frame_pkg::ST_PAYLOAD && take && last_pay && !client_beat.last) begin
        discard <= 1'b1;
      end else if (discard && take && client_beat.last) begin
        discard <= 1'b0;
      end
    end
  end

  // Auto pause on the rising crossing of the section-empty threshold.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      above_d <= 1'b0;
      auto_pend <= 1'b0;
    end else begin
      above_d <= above;
      if (above && !above_d && fc_ena) begin
        auto_pend <= 1'b1;
      end else if (state == mac_frame_pkg::ST_IDLE && pause_go) begin
        auto_pend <= 1'b0;
      end
    end
  end

  // Pin filters: a change counts once the second and third stages agree.
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_pin
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync1[g] <= 1'b0;
          sync2[g] <= 1'b0;
          sync3[g] <= 1'b0;
          pin_level[g] <= 1'b0;
        end else begin
          sync1[g] <= (g == 0) ? xoff_gen_pin : xon_gen_pin;
          sync2[g] <= sync1[g];
          sync3[g] <= sync2[g];
          if (sync2[g] == sync3[g]) begin
            pin_level[g] <= sync3[g];
          end
        end
      end
    end
  endgenerate

  // APB decode: one wait state, write lands on the completing edge.
  wire apb_access = psel && penable && !pready;
  wire apb_done = psel && penable && pready;
  wire wr_en = apb_done && pwrite && !pslverr;
  wire clr_stat = wr_en && paddr == mac_frame_pkg::OFS_STATUS;
  wire pay_end = state == mac_frame_pkg::ST_PAYLOAD && pay_done && !is_pause;
  wire lt_is_type = len_type >= mac_frame_pkg::TYPE_THRESHOLD;
  wire set_under = state == mac_frame_pkg::ST_PAYLOAD && !is_pause && !take;
  wire [31:0] status_word = {26'h0000000, st_mismatch, st_underrun, st_oversize, st_is_type,
    is_pause && state != mac_frame_pkg::ST_IDLE, state != mac_frame_pkg::ST_IDLE};
  logic [31:0] rd_word;
  always_comb begin
    case (paddr)
      mac_frame_pkg::OFS_CTRL: rd_word = {25'h0000000, ctrl};
      mac_frame_pkg::OFS_DA_LO: rd_word = dest_addr[31:0];
      mac_frame_pkg::OFS_DA_HI: rd_word = {16'h0000, dest_addr[47:32]};
      mac_frame_pkg::OFS_SA_LO: rd_word = src_addr[31:0];
      mac_frame_pkg::OFS_SA_HI: rd_word = {16'h0000, src_addr[47:32]};
      mac_frame_pkg::OFS_LEN_TYPE: rd_word = {16'h0000, len_type};
      mac_frame_pkg::OFS_VLAN_INFO: rd_word = vlan_info;
      mac_frame_pkg::OFS_QUANTA: rd_word = {16'h0000, quanta};
      mac_frame_pkg::OFS_SECTION_EMPTY: rd_word = {16'h0000, section_empty};
      mac_frame_pkg::OFS_STATUS: rd_word = status_word;
      default: rd_word = 32'h00000000;
    endcase
  end

  // Register file and sticky status; a hardware set beats a same-cycle clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
      ctrl <= mac_frame_pkg::CTRL_RESET;
      dest_addr <= 48'h000000000000;
      src_addr <= 48'h000000000000;
      len_type <= 16'h0000;
      vlan_info <= 32'h00000000;
      quanta <= mac_frame_pkg::QUANTA_RESET;
      section_empty <= mac_frame_pkg::SECTION_EMPTY_RESET;
      st_is_type <= 1'b0;
      st_oversize <= 1'b0;
      st_underrun <= 1'b0;
      st_mismatch <= 1'b0;
    end else begin
      pready <= apb_access;
      pslverr <= apb_access && !addr_known(paddr);
      prdata <= (apb_access && !pwrite) ? rd_word : 32'h00000000;
      if (wr_en) begin
        case (paddr)
          mac_frame_pkg::OFS_CTRL: ctrl <= pwdata[mac_frame_pkg::CTRL_WIDTH-1:0];
          mac_frame_pkg::OFS_DA_LO: dest_addr[31:0] <= pwdata;
          mac_frame_pkg::OFS_DA_HI: dest_addr[47:32] <= pwdata[15:0];
          mac_frame_pkg::OFS_SA_LO: src_addr[31:0] <= pwdata;
          mac_frame_pkg::OFS_SA_HI: src_addr[47:32] <= pwdata[15:0];
          mac_frame_pkg::OFS_LEN_TYPE: len_type <= pwdata[15:0];
          mac_frame_pkg::OFS_VLAN_INFO: vlan_info <= pwdata;
          mac_frame_pkg::OFS_QUANTA: quanta <= pwdata[15:0];
          mac_frame_pkg::OFS_SECTION_EMPTY: section_empty <= pwdata[15:0];
          default: ctrl <= ctrl;
        endcase
      end
      if (pay_end) begin
        st_is_type <= lt_is_type;
      end
      st_oversize <= (st_oversize && !(clr_stat && pwdata[mac_frame_pkg::STAT_OVERSIZE])) ||
        (pay_end && last_pay && !client_beat.last);
      st_underrun <= (st_underrun && !(clr_stat && pwdata[mac_frame_pkg::STAT_UNDERRUN])) ||
        set_under;
      st_mismatch <= (st_mismatch && !(clr_stat && pwdata[mac_frame_pkg::STAT_LEN_MISMATCH])) ||
        (pay_end && !lt_is_type && len_type[13:0] != pay_next);
    end
  end

endmodule

// ### verification/mac_frame_tx_properties.sv
module mac_frame_tx_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic client_ready,
  input wire logic [7:0] txd,
  input wire logic tx_en,
  input wire logic pause_active
);
  timeunit 1ns;
  timeprecision 1ns;
  // All checks run on the bus clock and rest while reset is low.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_one_wait; psel && penable && !pready |=> pready; endproperty
  a_one_wait: assert property (p_one_wait) else $error("bus answer not after one wait");
  property p_err_ready; pslverr |-> pready; endproperty
  a_err_ready: assert property (p_err_ready) else $error("error without ready");
  property p_preamble; $rose(tx_en) |-> (txd == 8'h55) [*7]; endproperty
  a_preamble: assert property (p_preamble) else $error("bad preamble");
  property p_delim; $rose(tx_en) |-> ##7 (tx_en && txd == 8'hD5); endproperty
  a_delim: assert property (p_delim) else $error("bad start delimiter");
  // No extension octets: the line stays silent for the first eight cycles of the gap.
  property p_gap; $fell(tx_en) |-> (!tx_en) [*8]; endproperty
  a_gap: assert property (p_gap) else $error("line active in gap");
  property p_ready_frame; client_ready |-> tx_en; endproperty
  a_ready_frame: assert property (p_ready_frame) else $error("payload outside frame");
  property p_pause_start; $rose(pause_active) |-> ##[0:2] tx_en; endproperty
  a_pause_start: assert property (p_pause_start) else $error("pause without frame");
  property p_pause_no_client; pause_active |-> !client_ready; endproperty
  a_pause_no_client: assert property (p_pause_no_client) else $error("client data in pause");
endmodule

bind mac_frame_tx mac_frame_tx_properties u_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .client_ready(client_ready), .txd(txd), .tx_en(tx_en), .pause_active(pause_active));

// ### verification/gmii_sink.sv
module gmii_sink (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] txd,
  input wire logic tx_en
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] fb [0:2047];
  logic en_d;
  int len;
  int frames;
  // The far station only listens and never sends, so it honours every pause.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      len <= 0;
      frames <= 0;
      en_d <= 1'b0;
    end else begin
      en_d <= tx_en;
      if (tx_en) fb[(tx_en && !en_d) ? 0 : len % 2048] <= txd;
      if (tx_en) len <= (tx_en && !en_d) ? 1 : len + 1;
      if (!tx_en && en_d) frames <= frames + 1;
    end
  end
endmodule

// ### verification/mac_frame_format_pause_gen_tb.sv
module mac_frame_format_pause_gen_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [47:0] PDA = 48'h0A0B0C0D0E0F; // Arbitrary pause destination.
  localparam logic [47:0] DA = 48'h1A2B3C4D5E6F;
  localparam logic [47:0] SA = 48'h665544332211;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, er;
  logic client_valid, client_ready, xoff_pin, xon_pin, tx_en, pause_active;
  logic [7:0] paddr, txd;
  logic [15:0] fill;
  logic [31:0] pwdata, prdata, rd;
  mac_frame_pkg::client_beat_t beat;
  logic [7:0] exp [$];
  int error_cnt, checks_done, base;

  // Bus clock at 10 MHz.
  always #50 pclk = ~pclk;

  mac_frame_tx #(.PAUSE_DEST_ADDR(PDA)) dut (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .client_valid(client_valid),
    .client_beat(beat), .client_ready(client_ready), .rx_fill_level(fill),
    .xoff_gen_pin(xoff_pin), .xon_gen_pin(xon_pin), .txd(txd), .tx_en(tx_en),
    .pause_active(pause_active));
  gmii_sink sink (.pclk(pclk), .presetn(presetn), .txd(txd), .tx_en(tx_en));

  task chk(input logic [31:0] got, input logic [31:0] want, input string m);
    checks_done++;
    if (got !== want) begin
      error_cnt++;
      $display("BAD %0t %s: got %h want %h", $time, m, got, want);
    end
  endtask

  task summarize();
    $display("checks_done %0d error_cnt %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task hang(input string m);
    error_cnt++;
    $display("BAD %0t %s timed out", $time, m);
    summarize();
  endtask

  // One transfer; the request stands until pready is seen high at an edge.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 20) hang("bus");
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task put(input logic [47:0] v, input int n, input bit msb);
    for (int i = 0; i < n; i++) exp.push_back(msb ? v[8 * (n - 1 - i) +: 8] : v[8 * i +: 8]);
  endtask

  task hdr(input logic [47:0] da);
    exp.delete();
    repeat (7) exp.push_back(8'h55);
    exp.push_back(8'hD5);
    put(da, 6, 0);
    put(SA, 6, 0);
  endtask

  // The CRC is built bit by bit here so that no shared code can hide a slip.
  task cmp_frame(input string m);
    logic [31:0] c;
    int t;
    logic pa;
    c = 32'hFFFFFFFF;
    pa = 1'b0;
    for (int i = 8; i < exp.size(); i++) begin
      c = c ^ {24'h0, exp[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 32'hEDB88320 : c >> 1;
    end
    put({16'h0, ~c}, 4, 0);
    for (t = 0; t < 5000 && sink.frames == base; t++) begin
      @(posedge pclk);
      pa |= pause_active;
    end
    if (t == 5000) hang(m);
    base = sink.frames;
    chk(sink.len, exp.size(), m);
    // The pause flag must show during a frame exactly when its type octet is the pause type.
    chk(pa, exp[20] == 8'h88, "pause flag");
    for (int i = 0; i < exp.size(); i++) if (sink.fb[i] !== exp[i]) begin
      chk(sink.fb[i], exp[i], m);
      break;
    end
  endtask

  // Valid stays high through the payload, since a gap would insert a zero byte.
  task send(input int n);
    int i;
    int t;
    i = 0;
    client_valid <= 1'b1;
    beat.data <= 8'hA0;
    beat.last <= (n == 1);
    for (t = 0; t < 3000 && i < n; t++) begin
      @(posedge pclk);
      if (client_ready === 1'b1) begin
        i++;
        beat.data <= 8'hA0 + 8'(i);
        beat.last <= (i == n - 1);
      end
    end
    if (i < n) hang("client");
    client_valid <= 1'b0;
  endtask

  task t_regs();
    apb(1'b0, mac_frame_pkg::OFS_SECTION_EMPTY, 32'h0);
    chk(rd, 32'h0000FFFF, "threshold reset");
    apb(1'b1, 8'h40, 32'hFFFFFFFF);
    chk(er, 1'b1, "unmapped");
    apb(1'b0, mac_frame_pkg::OFS_QUANTA, 32'h0);
    chk(rd, 32'h0000000F, "quanta reset");
    $display("register test done");
  endtask

  task t_data(input logic [1:0] vm, input logic [15:0] lt, input int pad);
    base = sink.frames;
    apb(1'b1, mac_frame_pkg::OFS_LEN_TYPE, {16'h0, lt});
    apb(1'b1, mac_frame_pkg::OFS_CTRL, {26'h0, vm, 4'h1});
    hdr(DA);
    if (vm != 2'd0) put(48'h81003333, 4, 1);
    if (vm == 2'd2) put(48'h81002222, 4, 1);
    put({32'h0, lt}, 2, 1);
    for (int i = 0; i < 3; i++) exp.push_back(8'hA0 + 8'(i));
    repeat (pad - 3) exp.push_back(8'h00);
    send(3);
    cmp_frame("data frame");
    apb(1'b0, mac_frame_pkg::OFS_STATUS, 32'h0);
    chk(rd[mac_frame_pkg::STAT_IS_TYPE], lt >= 16'h0600, "type flag");
    apb(1'b1, mac_frame_pkg::OFS_CTRL, 32'h0);
    $display("data frame test done");
  endtask

  // Register bits and pins are never used together, nor both requests at once.
  task t_pause(input logic [31:0] ctrl, input logic [1:0] pins, input logic [15:0] fl,
      input logic [15:0] q, input int nfr);
    base = sink.frames;
    apb(1'b1, mac_frame_pkg::OFS_CTRL, ctrl);
    @(posedge pclk);
    xoff_pin <= pins[0];
    xon_pin <= pins[1];
    fill <= fl;
    repeat (nfr) begin
      hdr(PDA);
      put({32'h88080001, q}, 6, 1);
      repeat (42) exp.push_back(8'h00);
      cmp_frame("pause frame");
    end
    apb(1'b1, mac_frame_pkg::OFS_CTRL, 32'h0);
    xoff_pin <= 1'b0;
    xon_pin <= 1'b0;
    fill <= 16'h0;
    repeat (200) @(posedge pclk);
    chk(sink.frames, base, "pause frames stop");
    $display("pause test done");
  endtask

  initial begin
    {presetn, psel, penable, pwrite, client_valid, xoff_pin, xon_pin} = 7'h00;
    {paddr, pwdata, fill, beat} = '0;
    {error_cnt, checks_done, base} = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    apb(1'b1, mac_frame_pkg::OFS_QUANTA, 32'h00001234);
    apb(1'b1, mac_frame_pkg::OFS_DA_LO, DA[31:0]);
    apb(1'b1, mac_frame_pkg::OFS_DA_HI, {16'h0, DA[47:32]});
    apb(1'b1, mac_frame_pkg::OFS_SA_LO, SA[31:0]);
    apb(1'b1, mac_frame_pkg::OFS_SA_HI, {16'h0, SA[47:32]});
    apb(1'b1, mac_frame_pkg::OFS_VLAN_INFO, 32'h22223333);
    t_data(2'd0, 16'h0800, 46);
    t_data(2'd1, 16'h0003, 42);
    t_data(2'd2, 16'h0003, 38);
    t_pause(32'h6, 2'b00, 16'h0, 16'h1234, 2);
    t_pause(32'hA, 2'b00, 16'h0, 16'h0000, 2);
    t_pause(32'h2, 2'b01, 16'h0, 16'h1234, 2);
    t_pause(32'h2, 2'b10, 16'h0, 16'h0000, 2);
    apb(1'b1, mac_frame_pkg::OFS_SECTION_EMPTY, 32'h00000100);
    t_pause(32'h2, 2'b00, 16'h0100, 16'h1234, 1);
    summarize();
  end
endmodule
